// ==== hdl/ucr_pkg.sv ====
// constants and carrier types for the user and current-share config words
package ucr_pkg;

  // management bus command codes of the two words
  localparam logic [7:0]  CMD_USER_CFG   = 8'hD1;
  localparam logic [7:0]  CMD_SHARE_CFG  = 8'hD2;

  // reset values
  localparam logic [15:0] USER_CFG_RST   = 16'h2011;
  localparam logic [15:0] SHARE_CFG_RST  = 16'h0000;

  // writable bit masks; reserved positions are fixed at their reset value
  localparam logic [15:0] USER_CFG_WMASK  = 16'hEB67;
  localparam logic [15:0] SHARE_CFG_WMASK = 16'hFFFD;

  // user word field positions
  localparam int USR_MIN_DUTY_HI  = 15;
  localparam int USR_MIN_DUTY_LO  = 14;
  localparam int USR_MIN_DUTY_EN  = 13;
  localparam int USR_SYNC_TMO_EN  = 11;
  localparam int USR_FF_BYPASS    = 9;
  localparam int USR_FAULT_SPREAD = 8;
  localparam int USR_SYNC_EXT_SEL = 6;
  localparam int USR_SYNC_DRIVE   = 5;
  localparam int USR_LS_ON_OFF    = 2;
  localparam int USR_STBY_HI      = 1;
  localparam int USR_STBY_LO      = 0;

  // share word field positions
  localparam int SHR_ID_HI        = 15;
  localparam int SHR_ID_LO        = 8;
  localparam int SHR_CNT_HI       = 7;
  localparam int SHR_CNT_LO       = 5;
  localparam int SHR_POS_HI       = 4;
  localparam int SHR_POS_LO       = 2;
  localparam int SHR_MEMBER       = 0;

  // standby mode codes
  localparam logic [1:0] STBY_LOW_POWER = 2'h0;
  localparam logic [1:0] STBY_MONITOR   = 2'h1;
  localparam logic [1:0] STBY_RESERVED  = 2'h2;
  localparam logic [1:0] STBY_PULSED    = 2'h3;

  // timing
  localparam int CLK_HZ          = 10_000_000;
  localparam int SYNC_TMO_MS     = 500;
  localparam int SYNC_TMO_CYCLES = (CLK_HZ / 1000) * SYNC_TMO_MS;
  localparam int SYNC_TMO_W      = 23;

  // duty floor numerator width: floor = value / 256
  localparam int DUTY_W          = 9;

  // decoded user word
  typedef struct packed {
    logic [1:0] min_duty;
    logic       min_duty_en;
    logic       sync_tmo_en;
    logic       ff_bypass;
    logic       fault_spread;
    logic       sync_ext_sel;
    logic       sync_drive;
    logic       ls_on_off;
    logic [1:0] stby_mode;
  } ucr_user_cfg_t;

  // decoded share word
  typedef struct packed {
    logic [7:0] rail_id;
    logic [2:0] member_cnt;
    logic [2:0] member_pos;
    logic       member;
  } ucr_share_cfg_t;

  // sync timeout states
  typedef enum logic [2:0] {
    SYNC_RUN   = 3'b001,
    SYNC_COUNT = 3'b010,
    SYNC_OFF   = 3'b100
  } ucr_sync_st_t;

endpackage

// ==== hdl/ucr_config_regs.sv ====
// user feature and current-share configuration words with their effects
// Overview of operation
// [R1] ramp duty floor is (N+1)/256
// [R2] floor only when min duty bit set
// [R3] sync output stops 500ms after disable
// [R4] feed-forward bit zero corrects coefficients
// [R5] spread zero: ignore or sequence down outward
// [R6] spread one: group fault shuts down immediately
// [R7] sync pin input only or driven out
// [R8] low-side drive state while disabled
// [R9] standby 00: low power, no telemetry
// [R10] standby 01: monitor faults, telemetry available
// [R11] standby 11: pulsed monitor, telemetry on read
// [R12] share word upper byte holds rail identifier
// [R13] share member uses share rail identifier
// [R14] software programs member count minus one
// [R15] member position taken from share word
// [R16] lowest share bit makes device member
// [R17] bus rail identifier selects own rail
// [R18] reserved bits read fixed, writes ignored
`timescale 1ns/1ps
`default_nettype none

module ucr_config_regs
  import ucr_pkg::*;
#(
  parameter int SYNC_TMO_CYC = SYNC_TMO_CYCLES
) (
  // clock and reset
  input  wire logic                 CLK_I,
  input  wire logic                 NRST_I,
  // word command port from the management bus engine
  input  wire logic [7:0]           CMD_I,
  input  wire logic                 WR_STB_I,
  input  wire logic [15:0]          WDATA_I,
  input  wire logic                 RD_STB_I,
  output logic      [15:0]          RDATA_O,
  output logic                      RVALID_O,
  output logic                      CMD_ERR_O,
  // converter state
  input  wire logic                 ENABLE_I,
  input  wire logic                 RAMP_I,
  output logic      [DUTY_W-1:0]    DUTY_FLOOR_O,
  output logic                      FF_CORRECT_O,
  output logic                      LS_DRIVE_ON_O,
  // sync pin
  input  wire logic                 SYNC_GEN_I,
  input  wire logic                 SYNC_PIN_I,
  output logic                      SYNC_PIN_O,
  output logic                      SYNC_PIN_OE_N_O,
  output logic                      SYNC_EXT_SEL_O,
  output logic                      SYNC_EXT_O,
  // inter-device bus faults
  input  wire logic [4:0]           RAIL_ID_I,
  input  wire logic                 SEQ_EN_I,
  input  wire logic                 FAULT_I,
  input  wire logic [4:0]           FAULT_RAIL_I,
  input  wire logic                 GROUP_HIT_I,
  output logic                      SHUTDOWN_O,
  output logic                      SEQ_DOWN_O,
  output logic      [4:0]           OWN_RAIL_O,
  // standby and telemetry
  input  wire logic                 TLM_REQ_I,
  output logic                      LOW_POWER_O,
  output logic                      FAULT_MON_O,
  output logic                      MON_PULSED_O,
  output logic                      TLM_AVAIL_O,
  // current share
  output logic                      SHARE_MEMBER_O,
  output logic      [2:0]           SHARE_CNT_O,
  output logic      [2:0]           SHARE_POS_O
);

  ////////////////////////////////////////////////////////////////////////
  // register words

  logic [15:0]    user_reg;
  logic [15:0]    share_reg;
  ucr_user_cfg_t  ucfg;
  ucr_share_cfg_t scfg;

  function automatic logic [15:0] merge_word(input logic [15:0] wd,
                                             input logic [15:0] mask,
                                             input logic [15:0] rst);
    merge_word = (wd & mask) | (rst & ~mask);
  endfunction

  // one bit per mapped word; shared by the write and error paths, the read path decodes CMD_I itself
  function automatic logic [1:0] cmd_sel(input logic [7:0] code);
    cmd_sel[0] = (code == CMD_USER_CFG);
    cmd_sel[1] = (code == CMD_SHARE_CFG);
  endfunction

  logic [1:0]  cmd_hit;
  logic [15:0] user_wr_val;
  logic [15:0] share_wr_val;

  assign cmd_hit      = cmd_sel(CMD_I);
  // reserved positions are rebuilt from the reset value, never from the host
  assign user_wr_val  = merge_word(WDATA_I, USER_CFG_WMASK, USER_CFG_RST);
  assign share_wr_val = merge_word(WDATA_I, SHARE_CFG_WMASK, SHARE_CFG_RST);

  // [R18] reserved bits fixed
  always_ff @(posedge CLK_I) begin
    if (!NRST_I) begin
      user_reg <= USER_CFG_RST;
    end else if (WR_STB_I && cmd_hit[0]) begin
      user_reg <= user_wr_val;
    end
  end

  // [R12] share rail identifier byte
  always_ff @(posedge CLK_I) begin
    if (!NRST_I) begin
      share_reg <= SHARE_CFG_RST;
    end else if (WR_STB_I && cmd_hit[1]) begin
      share_reg <= share_wr_val;
    end
  end

  always_comb begin
    ucfg.min_duty     = user_reg[USR_MIN_DUTY_HI:USR_MIN_DUTY_LO];
    ucfg.min_duty_en  = user_reg[USR_MIN_DUTY_EN];
    ucfg.sync_tmo_en  = user_reg[USR_SYNC_TMO_EN];
    ucfg.ff_bypass    = user_reg[USR_FF_BYPASS];
    ucfg.fault_spread = user_reg[USR_FAULT_SPREAD];
    ucfg.sync_ext_sel = user_reg[USR_SYNC_EXT_SEL];
    ucfg.sync_drive   = user_reg[USR_SYNC_DRIVE];
    ucfg.ls_on_off    = user_reg[USR_LS_ON_OFF];
    ucfg.stby_mode    = user_reg[USR_STBY_HI:USR_STBY_LO];
    scfg.rail_id      = share_reg[SHR_ID_HI:SHR_ID_LO];
    scfg.member_cnt   = share_reg[SHR_CNT_HI:SHR_CNT_LO];
    scfg.member_pos   = share_reg[SHR_POS_HI:SHR_POS_LO];
    scfg.member       = share_reg[SHR_MEMBER];
  end

  ////////////////////////////////////////////////////////////////////////
  // read answer, one cycle after the strobe

  always_ff @(posedge CLK_I) begin
    if (!NRST_I) begin
      RDATA_O   <= 16'h0000;
      RVALID_O  <= 1'b0;
      CMD_ERR_O <= 1'b0;
    end else begin
      RVALID_O  <= RD_STB_I;
      CMD_ERR_O <= (RD_STB_I || WR_STB_I) && cmd_hit == 2'b00;
      // unmapped reads answer zero rather than the last word read
      if (RD_STB_I) begin
        case (CMD_I)
          CMD_USER_CFG:  RDATA_O <= user_reg;
          CMD_SHARE_CFG: RDATA_O <= share_reg;
          default:       RDATA_O <= 16'h0000;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // ramp floor, feed-forward, low-side drive

  always_ff @(posedge CLK_I) begin
    if (!NRST_I) begin
      DUTY_FLOOR_O  <= '0;
      FF_CORRECT_O  <= 1'b1;
      LS_DRIVE_ON_O <= 1'b0;
    end else begin
      // numerator only; the modulator divides by 256
      // [R1] [R2] gated duty floor
      DUTY_FLOOR_O  <= (RAMP_I && ucfg.min_duty_en) ?
                       DUTY_W'({1'b0, ucfg.min_duty} + 3'h1) : '0;
      // [R4] feed-forward correction
      FF_CORRECT_O  <= !ucfg.ff_bypass;
      // [R8] low-side while disabled
      LS_DRIVE_ON_O <= !ENABLE_I && ucfg.ls_on_off;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // sync pin and its disable timeout

  ucr_sync_st_t          sync_st_reg;
  logic [SYNC_TMO_W-1:0] sync_cnt_reg;
  logic                  sync_meta_reg;
  logic                  sync_in_reg;
  logic                  sync_tmo_hit;
  logic                  sync_drv_on;

  // end two short: counting the RUN cycle, OFF is reached on cycle SYNC_TMO_CYC; the output flop adds one more
  assign sync_tmo_hit = (sync_cnt_reg == SYNC_TMO_W'(SYNC_TMO_CYC - 2));
  // drive only while the pin is an output and the timeout has not run out
  assign sync_drv_on  = ucfg.sync_drive && (sync_st_reg != SYNC_OFF);

  // [R3] timeout after disable
  always_ff @(posedge CLK_I) begin
    if (!NRST_I) begin
      sync_st_reg  <= SYNC_RUN;
      sync_cnt_reg <= '0;
    end else begin
      case (sync_st_reg)
        SYNC_RUN: begin
          sync_cnt_reg <= '0;
          if (!ENABLE_I && ucfg.sync_tmo_en) begin
            sync_st_reg <= SYNC_COUNT;
          end
        end
        SYNC_COUNT: begin
          sync_cnt_reg <= sync_cnt_reg + 1'b1;
          if (ENABLE_I || !ucfg.sync_tmo_en) begin
            sync_st_reg <= SYNC_RUN;
          end else if (sync_tmo_hit) begin
            sync_st_reg <= SYNC_OFF;
          end
        end
        SYNC_OFF: begin
          if (ENABLE_I || !ucfg.sync_tmo_en) begin
            sync_st_reg <= SYNC_RUN;
          end
        end
        default: sync_st_reg <= SYNC_RUN;
      endcase
    end
  end

  // pin is asynchronous to this clock
  always_ff @(posedge CLK_I) begin
    if (!NRST_I) begin
      sync_meta_reg <= 1'b0;
      sync_in_reg   <= 1'b0;
    end else begin
      sync_meta_reg <= SYNC_PIN_I;
      sync_in_reg   <= sync_meta_reg;
    end
  end

  // [R7] pin direction
  always_ff @(posedge CLK_I) begin
    if (!NRST_I) begin
      SYNC_PIN_O      <= 1'b0;
      SYNC_PIN_OE_N_O <= 1'b1;
      SYNC_EXT_SEL_O  <= 1'b0;
      SYNC_EXT_O      <= 1'b0;
    end else begin
      SYNC_PIN_O      <= sync_drv_on && SYNC_GEN_I;
      // released while off so the line is not held by a stopped output
      SYNC_PIN_OE_N_O <= !sync_drv_on;
      SYNC_EXT_SEL_O  <= ucfg.sync_ext_sel;
      SYNC_EXT_O      <= !ucfg.sync_drive && sync_in_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // rail identity and fault spreading

  logic [4:0] own_rail;
  logic       fault_foreign;

  // [R13] [R16] [R17] rail identity
  // only the low five bits of the share byte name a rail
  assign own_rail = scfg.member ? scfg.rail_id[4:0] : RAIL_ID_I;

  // a fault reported by this device's own rail is not spread back to it
  assign fault_foreign = FAULT_I && (FAULT_RAIL_I != own_rail);

  always_ff @(posedge CLK_I) begin
    if (!NRST_I) begin
      OWN_RAIL_O <= 5'h00;
      SHUTDOWN_O <= 1'b0;
      SEQ_DOWN_O <= 1'b0;
    end else begin
      OWN_RAIL_O <= own_rail;
      // [R6] immediate group shutdown
      SHUTDOWN_O <= fault_foreign && ucfg.fault_spread && GROUP_HIT_I;
      // [R5] sequence down or ignore
      SEQ_DOWN_O <= fault_foreign && !ucfg.fault_spread && SEQ_EN_I;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // standby monitoring and telemetry

  always_ff @(posedge CLK_I) begin
    if (!NRST_I) begin
      LOW_POWER_O  <= 1'b0;
      FAULT_MON_O  <= 1'b1;
      MON_PULSED_O <= 1'b0;
      TLM_AVAIL_O  <= 1'b1;
    // while running the standby code has no effect
    end else if (ENABLE_I) begin
      LOW_POWER_O  <= 1'b0;
      FAULT_MON_O  <= 1'b1;
      MON_PULSED_O <= 1'b0;
      TLM_AVAIL_O  <= 1'b1;
    end else begin
      case (ucfg.stby_mode)
        STBY_MONITOR: begin
          // [R10] continuous monitoring
          LOW_POWER_O  <= 1'b0;
          FAULT_MON_O  <= 1'b1;
          MON_PULSED_O <= 1'b0;
          TLM_AVAIL_O  <= 1'b1;
        end
        STBY_PULSED: begin
          // [R11] pulsed, telemetry on request
          LOW_POWER_O  <= 1'b0;
          FAULT_MON_O  <= 1'b1;
          MON_PULSED_O <= 1'b1;
          TLM_AVAIL_O  <= TLM_REQ_I;
        end
        default: begin
          // [R9] low power; reserved code treated alike
          LOW_POWER_O  <= 1'b1;
          FAULT_MON_O  <= 1'b0;
          MON_PULSED_O <= 1'b0;
          TLM_AVAIL_O  <= 1'b0;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // current share membership

  always_ff @(posedge CLK_I) begin
    if (!NRST_I) begin
      SHARE_MEMBER_O <= 1'b0;
      SHARE_CNT_O    <= 3'h0;
      SHARE_POS_O    <= 3'h0;
    end else begin
      // [R16] membership
      SHARE_MEMBER_O <= scfg.member;
      // [R14] count as programmed
      SHARE_CNT_O    <= scfg.member_cnt;
      // [R15] position in rail
      SHARE_POS_O    <= scfg.member_pos;
    end
  end

endmodule

`default_nettype wire

// ==== testbench/ucr_config_properties.sv ====
// concurrent checks on the config word port and its effect outputs
`timescale 1ns/1ps
`default_nettype none
module ucr_config_properties
  import ucr_pkg::*;
(
  // clock, reset and word port
  input wire logic              CLK_I,
  input wire logic              NRST_I,
  input wire logic [7:0]        CMD_I,
  input wire logic              WR_STB_I,
  input wire logic              RD_STB_I,
  input wire logic [15:0]       WDATA_I,
  input wire logic [15:0]       RDATA_O,
  input wire logic              RVALID_O,
  input wire logic              CMD_ERR_O,
  // converter and faults
  input wire logic              RAMP_I,
  input wire logic              SEQ_EN_I,
  input wire logic              FAULT_I,
  input wire logic              GROUP_HIT_I,
  input wire logic [4:0]        RAIL_ID_I,
  input wire logic [4:0]        FAULT_RAIL_I,
  // effects
  input wire logic [DUTY_W-1:0] DUTY_FLOOR_O,
  input wire logic              FF_CORRECT_O,
  input wire logic              SYNC_PIN_OE_N_O,
  input wire logic              SHUTDOWN_O,
  input wire logic              SEQ_DOWN_O,
  // sync pin
  input wire logic              SYNC_GEN_I,
  input wire logic              SYNC_PIN_I,
  input wire logic              SYNC_PIN_O,
  input wire logic              SYNC_EXT_SEL_O,
  input wire logic              SYNC_EXT_O
);
  logic [15:0] u_reg;
  logic [15:0] s_reg;
  logic [4:0]  own;
  logic        hit;
  logic [8:0]  duty;
  assign own = s_reg[0] ? s_reg[12:8] : RAIL_ID_I;
  assign hit = FAULT_I && FAULT_RAIL_I != own;
  assign duty = RAMP_I && u_reg[13] ? 9'(u_reg[15:14]) + 9'h001 : 9'h000;
  // shadow words; masks taken from the field list, not the design
  always_ff @(posedge CLK_I) begin
    if (!NRST_I) begin
      u_reg <= USER_CFG_RST;
      s_reg <= SHARE_CFG_RST;
    end else if (WR_STB_I && CMD_I == CMD_USER_CFG) begin
      u_reg <= (u_reg & 16'h1498) | (WDATA_I & 16'hEB67);
    end else if (WR_STB_I && CMD_I == CMD_SHARE_CFG) begin
      s_reg <= (s_reg & 16'h0002) | (WDATA_I & 16'hFFFD);
    end
  end
  default clocking cb @(posedge CLK_I);
  endclocking
  default disable iff (!NRST_I);
  rd_user_a: assert property (
    RD_STB_I && CMD_I == CMD_USER_CFG |=> RVALID_O && RDATA_O == $past(u_reg)
  ) else $error("user word read mismatch");
  rd_share_a: assert property (
    RD_STB_I && CMD_I == CMD_SHARE_CFG |=> RVALID_O && RDATA_O == $past(s_reg)
  ) else $error("share word read mismatch");
  bad_cmd_a: assert property (
    (WR_STB_I || RD_STB_I) && CMD_I != CMD_USER_CFG
      && CMD_I != CMD_SHARE_CFG |=> CMD_ERR_O
  ) else $error("unmapped command not flagged");
  duty_floor_a: assert property (
    DUTY_FLOOR_O == $past(duty)
  ) else $error("duty floor wrong");
  ff_corr_a: assert property (
    FF_CORRECT_O != $past(u_reg[9])
  ) else $error("feed-forward correction wrong");
  sync_input_a: assert property (
    !u_reg[5] |=> SYNC_PIN_OE_N_O
  ) else $error("sync pin driven while input only");
  shutdown_a: assert property (
    hit && GROUP_HIT_I && u_reg[8] |=> SHUTDOWN_O
  ) else $error("group fault did not shut down");
  seq_down_a: assert property (
    hit && SEQ_EN_I && !u_reg[8] |=> SEQ_DOWN_O
  ) else $error("fault did not start sequence down");
  sync_drive_a: assert property (
    !SYNC_PIN_OE_N_O |-> SYNC_PIN_O == $past(SYNC_GEN_I)
  ) else $error("sync pin drive does not follow generator");
  sync_quiet_a: assert property (
    SYNC_PIN_OE_N_O |-> !SYNC_PIN_O
  ) else $error("sync pin value while released");
  ext_sel_a: assert property (
    SYNC_EXT_SEL_O == $past(u_reg[6])
  ) else $error("external sync select wrong");
  sync_ext_a: assert property (
    $past(NRST_I, 3) && $past(NRST_I, 2) && $past(NRST_I) |->
      SYNC_EXT_O == (!$past(u_reg[5]) && $past(SYNC_PIN_I, 3))
  ) else $error("synchronised sync input wrong");
endmodule
bind ucr_config_regs ucr_config_properties u_props (
  .CLK_I, .NRST_I, .CMD_I, .WR_STB_I, .RD_STB_I, .WDATA_I, .RDATA_O,
  .RVALID_O, .CMD_ERR_O, .RAMP_I, .SEQ_EN_I, .FAULT_I, .GROUP_HIT_I,
  .RAIL_ID_I, .FAULT_RAIL_I, .DUTY_FLOOR_O, .FF_CORRECT_O,
  .SYNC_PIN_OE_N_O, .SHUTDOWN_O, .SEQ_DOWN_O, .SYNC_GEN_I, .SYNC_PIN_I,
  .SYNC_PIN_O, .SYNC_EXT_SEL_O, .SYNC_EXT_O
);
`default_nettype wire

// ==== testbench/ucr_host_model.sv ====
// management bus host issuing whole word writes and reads
`timescale 1ns/1ps
`default_nettype none
module ucr_host_model (
  // clock and answer
  input  wire logic        clk_i,
  input  wire logic [15:0] rdata_i,
  input  wire logic        rvalid_i,
  input  wire logic        err_i,
  // request
  output var  logic [7:0]  cmd_o,
  output var  logic        wr_o,
  output var  logic        rd_o,
  output var  logic [15:0] wdata_o
);
  initial begin
    {cmd_o, wr_o, rd_o, wdata_o} = '0;
  end
  // caller supplies fields as software sets them
  task automatic wr(input logic [7:0] c, input logic [15:0] d);
    @(negedge clk_i);
    {cmd_o, wdata_o, wr_o} = {c, d, 1'b1};
    @(negedge clk_i);
    {cmd_o, wdata_o, wr_o} = {~c, ~d, 1'b0};
  endtask
  task automatic rd(input logic [7:0] c, output logic [16:0] a, output bit ok);
    int n;
    @(negedge clk_i);
    {cmd_o, rd_o} = {c, 1'b1};
    @(negedge clk_i);
    {cmd_o, rd_o} = {~c, 1'b0};
    ok = 1'b0;
    for (n = 0; n < 4 && !ok; n++) begin
      if (rvalid_i === 1'b1 || err_i === 1'b1) ok = 1'b1;
      else @(negedge clk_i);
    end
    a = {err_i, rdata_i};
  endtask
endmodule
`default_nettype wire

// ==== testbench/tb_top.sv ====
// self-checking bench for the config words and their effects
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import ucr_pkg::*;
;
  localparam int TMO = 20;
  logic clk, nrst, wr, rd, en, ramp, sg, sp, seq, flt, grp, rv, cerr;
  logic ffc, ls, oen, sd, sq, lp, fm, mp, shm, treq, tav;
  logic [5:0] sb;
  logic [7:0] cmd, c;
  logic [15:0] wd, rdat, d;
  logic [4:0] rid, frail, orail;
  logic [8:0] duty;
  logic [2:0] scnt, spos;
  logic [16:0] a;
  bit ok;
  int n_mismatch, num_checks, user, share, i;
  ucr_host_model u_host (
    .clk_i(clk), .rdata_i(rdat), .rvalid_i(rv), .err_i(cerr),
    .cmd_o(cmd), .wr_o(wr), .rd_o(rd), .wdata_o(wd));
  ucr_config_regs #(.SYNC_TMO_CYC(TMO)) DUT (
    .CLK_I(clk), .NRST_I(nrst), .CMD_I(cmd), .WR_STB_I(wr), .WDATA_I(wd),
    .RD_STB_I(rd), .RDATA_O(rdat), .RVALID_O(rv), .CMD_ERR_O(cerr),
    .ENABLE_I(en), .RAMP_I(ramp), .DUTY_FLOOR_O(duty), .FF_CORRECT_O(ffc),
    .LS_DRIVE_ON_O(ls), .SYNC_GEN_I(sg), .SYNC_PIN_I(sp), .SYNC_PIN_O(),
    .SYNC_PIN_OE_N_O(oen), .SYNC_EXT_SEL_O(), .SYNC_EXT_O(),
    .RAIL_ID_I(rid), .SEQ_EN_I(seq), .FAULT_I(flt), .FAULT_RAIL_I(frail),
    .GROUP_HIT_I(grp), .SHUTDOWN_O(sd), .SEQ_DOWN_O(sq), .OWN_RAIL_O(orail),
    .TLM_REQ_I(treq), .LOW_POWER_O(lp), .FAULT_MON_O(fm),
    .MON_PULSED_O(mp), .TLM_AVAIL_O(tav), .SHARE_MEMBER_O(shm),
    .SHARE_CNT_O(scnt), .SHARE_POS_O(spos));
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  always @(negedge clk) begin
    sg <= 1'($urandom);
    sp <= 1'($urandom);
  end
  task automatic close_out();
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic chk(input logic [16:0] got, input logic [16:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // model keeps reserved positions at their reset value
  task automatic wrm(input logic [7:0] k, input logic [15:0] v);
    u_host.wr(k, v);
    if (k == CMD_USER_CFG) user = (user & 'h1498) | (v & 'hEB67);
    if (k == CMD_SHARE_CFG) share = (share & 'h0002) | (v & 'hFFFD);
  endtask
  task automatic rdc(input logic [7:0] k, input logic [16:0] e);
    u_host.rd(k, a, ok);
    if (!ok) begin
      n_mismatch++;
      close_out();
    end
    chk(a, e);
  endtask
  task automatic pulse(input logic [4:0] r, input logic [1:0] e);
    @(negedge clk);
    frail = r;
    flt = 1'b1;
    @(negedge clk);
    flt = 1'b0;
    chk(17'({sd, sq}), 17'(e));
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    close_out();
  end
  initial begin
    void'($urandom(25420));
    {nrst, en, ramp, seq, flt, grp, treq} = '0;
    {rid, frail} = {5'h05, 5'h00};
    {n_mismatch, num_checks, user, share} = {32'h0, 32'h0, 32'h2011, 32'h0};
    repeat (8) @(negedge clk);
    nrst = 1'b1;
    rdc(CMD_USER_CFG, 17'(user));
    rdc(CMD_SHARE_CFG, 17'(share));
    rdc(8'hD3, 17'h1_0000);
    for (i = 0; i < 24; i++) begin
      c = i[0] ? CMD_SHARE_CFG : CMD_USER_CFG;
      d = 16'($urandom) & (i[0] ? 16'h1FFF : 16'hFFFF);
      wrm(c, d);
      if (i % 4 == 3) u_host.wr(8'hD0, ~d);
      rdc(c, 17'(i[0] ? share : user));
    end
    repeat (2) @(negedge clk);
    chk(17'({scnt, spos, shm}), 17'({share[7:2], share[0]}));
    for (i = 0; i < 4; i++) begin
      treq = 1'($urandom);
      wrm(CMD_USER_CFG, {6'h00, i[1], 6'h00, i[0], i[1:0]});
      repeat (2) @(negedge clk);
      sb = {~i[0], i[0], i[0] & i[1], i[0], ~i[1], i[0] & (~i[1] | treq)};
      chk(17'({lp, fm, mp, ls, ffc, tav}), 17'(sb));
    end
    ramp = 1'b1;
    for (i = 0; i < 8; i++) begin
      wrm(CMD_USER_CFG, {i[1:0], i[2], 13'h0000});
      repeat (2) @(negedge clk);
      chk(17'(duty), i[2] ? 17'(i[1:0]) + 17'h1 : 17'h0);
    end
    ramp = 1'b0;
    en = 1'b1;
    wrm(CMD_USER_CFG, 16'h0820);
    repeat (2) @(negedge clk);
    chk(17'(oen), 17'h0);
    en = 1'b0;
    for (i = 0; i < 60 && oen !== 1'b1; i++) @(negedge clk);
    chk(17'(i >= TMO && i <= TMO + 3), 17'h1);
    en = 1'b1;
    wrm(CMD_USER_CFG, 16'h0020);
    repeat (2) @(negedge clk);
    chk(17'(oen), 17'h0);
    en = 1'b0;
    repeat (2 * TMO) @(negedge clk);
    chk(17'(oen), 17'h0);
    wrm(CMD_USER_CFG, 16'h0000);
    repeat (2) @(negedge clk);
    chk(17'(oen), 17'h1);
    wrm(CMD_SHARE_CFG, 16'h0000);
    repeat (2) @(negedge clk);
    chk(17'(orail), 17'h5);
    {seq, grp} = 2'b11;
    pulse(5'h03, 2'b01);
    pulse(5'h05, 2'b00);
    seq = 1'b0;
    pulse(5'h03, 2'b00);
    wrm(CMD_USER_CFG, 16'h0100);
    repeat (2) @(negedge clk);
    pulse(5'h03, 2'b10);
    grp = 1'b0;
    pulse(5'h03, 2'b00);
    grp = 1'b1;
    wrm(CMD_SHARE_CFG, 16'h0301);
    repeat (2) @(negedge clk);
    chk(17'(orail), 17'h3);
    pulse(5'h05, 2'b10);
    pulse(5'h03, 2'b00);
    close_out();
  end
endmodule
`default_nettype wire
